// ===== core/sadc_defines.svh
/*
  Timing constants and pin-level encodings for the serial converter control block.
  Assumes the core clock runs at 250 MHz (4 ns period).
*/
`ifndef SADC_DEFINES_SVH
`define SADC_DEFINES_SVH

`define SADC_CLK_PERIOD_PS    4000
`define SADC_BUSY_DELAY_NS    100
`define SADC_SCLK_DELAY_NS    260
`define SADC_SCLK_PERIOD_NS   150
`define SADC_CONV_TIME_NS     3000
`define SADC_PREV_HOLD_NS     2200
`define SADC_BUSY_DELAY_CYC   ((`SADC_BUSY_DELAY_NS * 1000) / `SADC_CLK_PERIOD_PS)
`define SADC_SCLK_DELAY_CYC   ((`SADC_SCLK_DELAY_NS * 1000) / `SADC_CLK_PERIOD_PS)
`define SADC_SCLK_HALF_CYC    ((`SADC_SCLK_PERIOD_NS * 1000) / (2 * `SADC_CLK_PERIOD_PS))
`define SADC_PREV_HOLD_CYC    ((`SADC_PREV_HOLD_NS * 1000 + `SADC_CLK_PERIOD_PS - 1) / `SADC_CLK_PERIOD_PS)
`define SADC_CONV_CYC         (`SADC_PREV_HOLD_CYC + 8'h10)
`define SADC_WORD_BITS        16
`define SADC_BIT_CNT_LAST     5'h10
`define SADC_MSB_FLIP         16'h8000
`define SADC_SEL_EXTERNAL     1'h1
`define SADC_FMT_BINARY       1'h1

`endif

// ===== core/sadc_pkg.sv
/*
  Types shared by the serial converter control block.
  Assumes sadc_defines.svh is included by the design files that use it.
*/
package sadc_pkg;

  typedef enum logic [1:0] {
    SADC_IDLE   = 2'b00,
    SADC_CONV   = 2'b01,
    SADC_FINISH = 2'b11
  } sadc_state_t;

  typedef struct packed {
    logic chip_select_n;
    logic read_convert;
    logic shift_clock_in;
    logic chain_in;
  } sadc_pins_t;

endpackage : sadc_pkg

// ===== core/sadc_sync.sv
/*
  Two-flop synchroniser for a group of asynchronous pin levels.
  Assumes the inputs may change at any time relative to clk.
*/
`timescale 1ns/1ps
module sadc_sync #(
  parameter int WIDTH = 4
) (
  // Clock and reset
  input  wire logic             clk,
  input  wire logic             reset_n,
  // Levels
  input  wire logic [WIDTH-1:0] async_in,
  output logic      [WIDTH-1:0] sync_out
);

  logic [WIDTH-1:0] meta_reg;

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      meta_reg <= '0;
      sync_out <= '0;
    end else begin
      meta_reg <= async_in;
      sync_out <= meta_reg;
    end
  end

endmodule : sadc_sync

// ===== core/sadc_core.sv
/*
  Conversion control and serial readout of a 16-bit successive-approximation converter.
  Assumes all pin inputs are asynchronous to clk; the converted word arrives from the analog side.
*/
`timescale 1ns/1ps
`include "sadc_defines.svh"

module sadc_core (
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        reset_n,
  // Host pins
  input  wire logic        chip_select_n,
  input  wire logic        read_convert,
  input  wire logic        shift_clock_source_sel,
  input  wire logic        output_format_sel,
  input  wire logic        power_down_pin,
  input  wire logic        chain_in,
  // Shift clock pin, two-way
  input  wire logic        serial_shift_clock_in,
  output logic             serial_shift_clock_out,
  output logic             serial_shift_clock_oe,
  // Status and data outputs
  output logic             busy_n,
  output logic             serial_data,
  // Analog side result
  input  wire logic [15:0] sar_result
);

  sadc_pkg::sadc_pins_t pins_raw;
  sadc_pkg::sadc_pins_t pins;
  sadc_pkg::sadc_pins_t pins_prev;
  logic [2:0]           cfg_sync;
  logic [2:0]           cfg_meta;

  assign pins_raw = '{chip_select_n, read_convert, serial_shift_clock_in, chain_in};

  sadc_sync #(.WIDTH(4)) u_pin_sync (
    .clk      (clk),
    .reset_n  (reset_n),
    .async_in (pins_raw),
    .sync_out (pins)
  );

  // Strap pins pass two flops as well.
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      cfg_meta <= '0;
      cfg_sync <= '0;
    end else begin
      cfg_meta <= {shift_clock_source_sel, output_format_sel, power_down_pin};
      cfg_sync <= cfg_meta;
    end
  end

  logic ext_mode;
  logic fmt_binary;
  logic pwr_down;
  assign ext_mode   = (cfg_sync[2] == `SADC_SEL_EXTERNAL);
  assign fmt_binary = (cfg_sync[1] == `SADC_FMT_BINARY);
  assign pwr_down   = cfg_sync[0];

  // The select and convert lines are ORed, so the later of their two falling edges starts a conversion.
  logic gate_now;
  logic gate_prev;
  logic start_evt;
  logic enable_evt;
  logic sclk_rise;
  assign gate_now   = pins.chip_select_n | pins.read_convert;
  assign gate_prev  = pins_prev.chip_select_n | pins_prev.read_convert;
  assign sclk_rise  = pins.shift_clock_in & ~pins_prev.shift_clock_in;

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      pins_prev <= '0;
    end else begin
      pins_prev <= pins;
    end
  end

  sadc_pkg::sadc_state_t state_reg;
  logic [15:0]           conv_cnt_reg;
  logic [15:0]           result_reg;
  logic [15:0]           shift_reg;
  logic                  chain_level_reg;
  logic [4:0]            out_cnt_reg;
  logic                  ext_enable_reg;

  assign start_evt  = gate_prev & ~gate_now & (state_reg == sadc_pkg::SADC_IDLE) & ~pwr_down;
  assign enable_evt = ~pins_prev.read_convert & pins.read_convert & ~pins.chip_select_n;

  // Conversion sequencer; a running conversion cannot be restarted.
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      state_reg    <= sadc_pkg::SADC_IDLE;
      conv_cnt_reg <= '0;
    end else begin
      unique case (state_reg)
        sadc_pkg::SADC_IDLE: begin
          if (start_evt) begin
            state_reg    <= sadc_pkg::SADC_CONV;
            conv_cnt_reg <= '0;
          end
        end
        sadc_pkg::SADC_CONV: begin
          conv_cnt_reg <= conv_cnt_reg + 16'h0001;
          if (conv_cnt_reg == 16'(`SADC_CONV_CYC - 1)) begin
            state_reg    <= sadc_pkg::SADC_FINISH;
            conv_cnt_reg <= '0;
          end
        end
        sadc_pkg::SADC_FINISH: begin
          conv_cnt_reg <= conv_cnt_reg + 16'h0001;
          if (conv_cnt_reg == 16'(`SADC_BUSY_DELAY_CYC - 1)) begin
            state_reg <= sadc_pkg::SADC_IDLE;
          end
        end
      endcase
    end
  end

  // Busy stays low from start until the post-conversion delay has elapsed.
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      busy_n <= 1'b1;
    end else begin
      busy_n <= ~(start_evt | (state_reg == sadc_pkg::SADC_CONV)
                 | ((state_reg == sadc_pkg::SADC_FINISH) && (conv_cnt_reg != 16'(`SADC_BUSY_DELAY_CYC - 1))));
    end
  end

  // Result latch. Bipolar complement flips the MSB so zero sits between all ones and all zeros.
  logic conv_done;
  assign conv_done = (state_reg == sadc_pkg::SADC_CONV) && (conv_cnt_reg == 16'(`SADC_CONV_CYC - 1));

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      result_reg <= '0;
    end else if (conv_done) begin
      result_reg <= fmt_binary ? sar_result : (sar_result ^ `SADC_MSB_FLIP);
    end
  end

  // Internal shift clock generator: delay, then sixteen pulses of the previous result.
  logic [7:0] sclk_cnt_reg;
  logic       sclk_run_reg;
  logic       sclk_wait_reg;

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      sclk_wait_reg          <= 1'b0;
      sclk_run_reg           <= 1'b0;
      sclk_cnt_reg           <= '0;
      serial_shift_clock_out <= 1'b0;
    end else if (start_evt && !ext_mode) begin
      sclk_wait_reg <= 1'b1;
      sclk_cnt_reg  <= '0;
    end else if (sclk_wait_reg) begin
      sclk_cnt_reg <= sclk_cnt_reg + 8'h01;
      if (sclk_cnt_reg == 8'(`SADC_SCLK_DELAY_CYC - 1)) begin
        sclk_wait_reg          <= 1'b0;
        sclk_run_reg           <= 1'b1;
        sclk_cnt_reg           <= '0;
        serial_shift_clock_out <= 1'b1;
      end
    end else if (sclk_run_reg) begin
      sclk_cnt_reg <= sclk_cnt_reg + 8'h01;
      if (sclk_cnt_reg == 8'(`SADC_SCLK_HALF_CYC - 1)) begin
        sclk_cnt_reg           <= '0;
        serial_shift_clock_out <= ~serial_shift_clock_out;
        if (serial_shift_clock_out && out_cnt_reg == `SADC_BIT_CNT_LAST) begin
          sclk_run_reg <= 1'b0;
        end
      end
    end else begin
      serial_shift_clock_out <= 1'b0;
    end
  end

  assign serial_shift_clock_oe = ~ext_mode;

  // Output shifter. The previous word is kept until fully shifted, well past the hold time.
  logic int_shift;
  assign int_shift = sclk_run_reg && (sclk_cnt_reg == 8'(`SADC_SCLK_HALF_CYC - 1)) && serial_shift_clock_out;

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      shift_reg       <= '0;
      out_cnt_reg     <= '0;
      ext_enable_reg  <= 1'b0;
      chain_level_reg <= 1'b0;
    end else begin
      if (start_evt) begin
        chain_level_reg <= pins.chain_in;
      end
      if (!ext_mode) begin
        if (start_evt) begin
          shift_reg   <= result_reg;
          out_cnt_reg <= 5'h01;
        end else if (int_shift && out_cnt_reg != `SADC_BIT_CNT_LAST) begin
          shift_reg   <= {shift_reg[14:0], 1'b0};
          out_cnt_reg <= out_cnt_reg + 5'h01;
        end
        ext_enable_reg <= 1'b0;
      end else begin
        if (enable_evt || (pins_prev.chip_select_n && !pins.chip_select_n && pins.read_convert)) begin
          shift_reg      <= result_reg;
          out_cnt_reg    <= '0;
          ext_enable_reg <= 1'b1;
        end else if (ext_enable_reg && sclk_rise) begin
          shift_reg <= {shift_reg[14:0], pins.chain_in};
          if (out_cnt_reg != `SADC_BIT_CNT_LAST) begin
            out_cnt_reg <= out_cnt_reg + 5'h01;
          end
        end
        if (gate_now == 1'b1 && pins.chip_select_n) begin
          ext_enable_reg <= 1'b0;
        end
      end
    end
  end

  // Data output: shifter MSB while shifting, else the captured chain level.
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      serial_data <= 1'b0;
    end else if (ext_mode) begin
      serial_data <= ext_enable_reg ? shift_reg[15] : chain_level_reg;
    end else begin
      serial_data <= (out_cnt_reg != '0 && (sclk_run_reg || sclk_wait_reg)) ? shift_reg[15] : chain_level_reg;
    end
  end

endmodule : sadc_core

// ===== test/sadc_core_assertions.sv
/*
  Port-level checks on conversion timing and the internal shift clock.
  Assumes binding to sadc_core with clk at 250 MHz.
*/
`timescale 1ns/1ps
module sadc_checker (
  // Clock and reset
  input wire logic clk,
  input wire logic reset_n,
  // Observed pins
  input wire logic chip_select_n,
  input wire logic read_convert,
  input wire logic shift_clock_source_sel,
  input wire logic power_down_pin,
  input wire logic serial_shift_clock_out,
  input wire logic serial_shift_clock_oe,
  input wire logic busy_n
);
  default clocking @(posedge clk); endclocking
  default disable iff (!reset_n);
  logic [9:0] low_cnt;
  logic [4:0] pulse_cnt;
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) low_cnt <= 10'h000;
    else low_cnt <= busy_n ? 10'h000 : low_cnt + 10'h001;
  end
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) pulse_cnt <= 5'h00;
    else if ($fell(busy_n)) pulse_cnt <= 5'h00;
    else if ($rose(serial_shift_clock_out)) pulse_cnt <= pulse_cnt + 5'h01;
  end
  sequence s_start;
    $fell(read_convert) && !chip_select_n && busy_n && !power_down_pin;
  endsequence
  sequence s_int_start;
    $fell(busy_n) && !shift_clock_source_sel;
  endsequence
  a_busy_start: assert property (s_start |-> ##[1:6] !busy_n)
    else $error("busy did not fall after a start");
  a_busy_min: assert property ($rose(busy_n) |-> low_cnt > 10'h225)
    else $error("busy low too short");
  a_busy_max: assert property ($rose(busy_n) |-> low_cnt < 10'h2EF)
    else $error("busy low too long");
  a_first_pulse: assert property (s_int_start |->
    (!serial_shift_clock_out throughout ##55 1'b1) ##[1:20] serial_shift_clock_out)
    else $error("first shift clock pulse out of place");
  a_pulse_high: assert property ($rose(serial_shift_clock_out) |->
    serial_shift_clock_out [*8] ##[1:20] !serial_shift_clock_out)
    else $error("shift clock high time wrong");
  a_pulse_count: assert property (pulse_cnt < 5'h11)
    else $error("more than sixteen shift clock pulses");
  a_oe_mode: assert property ($stable(shift_clock_source_sel) [*8] |->
    serial_shift_clock_oe == !shift_clock_source_sel)
    else $error("shift clock enable does not follow mode");
  a_ext_quiet: assert property (shift_clock_source_sel [*8] |-> !serial_shift_clock_out)
    else $error("shift clock driven in external mode");
endmodule : sadc_checker

bind sadc_core sadc_checker u_chk (.clk(clk), .reset_n(reset_n), .chip_select_n(chip_select_n),
  .read_convert(read_convert), .shift_clock_source_sel(shift_clock_source_sel),
  .power_down_pin(power_down_pin), .serial_shift_clock_out(serial_shift_clock_out),
  .serial_shift_clock_oe(serial_shift_clock_oe), .busy_n(busy_n));

// ===== test/sadc_host.sv
/*
  Host model: starts conversions and collects the serial words.
  Assumes the bench calls convert and wires it to the converter pins.
*/
`timescale 1ns/1ps
module sadc_host (
  // Clock
  input wire logic  clk,
  // Device pins
  input wire logic  busy_n,
  input wire logic  clock_seen,
  input wire logic  serial_data,
  output logic      chip_select_n,
  output logic      read_convert,
  output logic      shift_clock_ext,
  // Collected data
  output logic [15:0] word,
  output logic [4:0]  pulses
);
  int low_len;
  initial begin
    chip_select_n = 1'h0;
    read_convert = 1'h1;
    shift_clock_ext = 1'h0;
    word = 16'h0000;
    pulses = 5'h00;
  end
  always @(posedge clk) if (!busy_n) low_len++;
  always @(posedge clock_seen) begin
    word = {word[14:0], serial_data};
    pulses = pulses + 5'h01;
  end
  task automatic clock_out(input int n);
    // Sample just before each rise, so the shift of the previous rise has settled.
    repeat (n) begin
      word = {word[14:0], serial_data};
      pulses = pulses + 5'h01;
      #24 shift_clock_ext = 1'h1;
      #24 shift_clock_ext = 1'h0;
    end
  endtask : clock_out
  task automatic convert(input logic ext, input logic dbl, output int len);
    low_len = 0;
    pulses = 5'h00;
    @(negedge clk) read_convert = 1'h0;
    repeat (40) @(negedge clk);
    read_convert = 1'h1;
    if (dbl) begin
      repeat (100) @(negedge clk);
      read_convert = 1'h0;
      repeat (40) @(negedge clk);
      read_convert = 1'h1;
    end
    if (ext) begin
      repeat (8) @(negedge clk);
      clock_out(16);
    end
    for (int i = 0; i < 900; i++) begin
      if (busy_n && low_len > 0) break;
      @(negedge clk);
    end
    len = low_len;
    repeat (500) @(negedge clk);
  endtask : convert
endmodule : sadc_host

// ===== test/tb.sv
/*
  Self-checking bench for the converter control block.
  Assumes the host model drives the pins; the bench plays the analog result.
*/
`timescale 1ns/1ps
module tb;
  logic        clk = 1'h0;
  logic        reset_n = 1'h0;
  logic        ext_sel = 1'h0;
  logic        fmt_sel = 1'h1;
  logic        pd = 1'h0;
  logic        chain = 1'h0;
  logic [15:0] sar = 16'h0000;
  logic        cs_n, rc, sck_ext, sck_out, sck_oe, busy_n, sdata, sck_pin;
  logic [15:0] word;
  logic [4:0]  pulses;
  int          errors = 0;
  int          checked = 0;
  int          cycles = 0;
  always #2 clk = ~clk;
  assign sck_pin = sck_oe ? sck_out : sck_ext;
  sadc_core DUT (.clk(clk), .reset_n(reset_n), .chip_select_n(cs_n), .read_convert(rc),
    .shift_clock_source_sel(ext_sel), .output_format_sel(fmt_sel), .power_down_pin(pd),
    .chain_in(chain), .serial_shift_clock_in(sck_pin), .serial_shift_clock_out(sck_out),
    .serial_shift_clock_oe(sck_oe), .busy_n(busy_n), .serial_data(sdata), .sar_result(sar));
  sadc_host HOST (.clk(clk), .busy_n(busy_n), .clock_seen(sck_out), .serial_data(sdata),
    .chip_select_n(cs_n), .read_convert(rc), .shift_clock_ext(sck_ext), .word(word), .pulses(pulses));
  task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
    checked++;
    if (seen !== exp) begin
      errors++;
      $display("unexpected %s: expected %h seen %h", name, exp, seen);
    end
  endtask : check
  task automatic results;
    $display("errors %0d checked %0d", errors, checked);
    if (errors == 0 && checked > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask : results
  function automatic logic [15:0] fmt(input logic [15:0] v);
    return fmt_sel ? v : v ^ 16'h8000;
  endfunction : fmt
  task automatic conv(input logic [15:0] v, input logic dbl, output int len);
    sar = v;
    HOST.convert(ext_sel, dbl, len);
  endtask : conv
  task automatic t_stream(input logic e, input logic f);
    int len;
    ext_sel = e;
    fmt_sel = f;
    repeat (20) @(negedge clk);
    check("oe", {15'h0000, sck_oe}, {15'h0000, !e});
    conv(16'h8000, 1'h0, len);
    conv(16'h7FFF, 1'h0, len);
    check("word", word, f ? 16'h8000 : 16'h0000);
    check("busy", {15'h0000, len > 549 && len < 751}, 16'h0001);
    conv(16'h1234, 1'h0, len);
    check("word", word, f ? 16'h7FFF : 16'hFFFF);
    check("pulses", {11'h000, pulses}, 16'h0010);
    $display("stream test done ext %0d fmt %0d", e, f);
  endtask : t_stream
  task automatic t_chain;
    int len;
    ext_sel = 1'h1;
    chain = 1'h1;
    repeat (20) @(negedge clk);
    conv(16'h4321, 1'h0, len);
    check("word", word, fmt(16'h1234));
    HOST.clock_out(16);
    check("chain", word, 16'hFFFF);
    chain = 1'h0;
    $display("chain test done");
  endtask : t_chain
  task automatic t_refuse;
    int len;
    ext_sel = 1'h0;
    pd = 1'h1;
    repeat (20) @(negedge clk);
    conv(16'hA5A5, 1'h0, len);
    check("pd busy", len[15:0], 16'h0000);
    pd = 1'h0;
    repeat (8) @(negedge clk);
    conv(16'h5A5A, 1'h1, len);
    check("word", word, fmt(16'h4321));
    check("busy", {15'h0000, len > 549 && len < 751}, 16'h0001);
    conv(16'h0000, 1'h0, len);
    check("word", word, fmt(16'h5A5A));
    $display("refusal test done");
  endtask : t_refuse
  always @(posedge clk) begin
    cycles++;
    if (cycles == 30000) begin
      errors++;
      results();
    end
  end
  initial begin
    repeat (12) @(negedge clk);
    reset_n = 1'h1;
    repeat (8) @(negedge clk);
    t_stream(1'h0, 1'h1);
    t_stream(1'h0, 1'h0);
    t_stream(1'h1, 1'h1);
    t_stream(1'h1, 1'h0);
    t_chain();
    t_refuse();
    results();
  end
endmodule : tb
